// ---- rtl/regs_defines.svh ----
// Offsets, field positions, reset values and codes of the port status block.
// Assumes byte addressing on a 12-bit configuration window.
`ifndef REGS_DEFINES_SVH
`define REGS_DEFINES_SVH

// Register byte offsets
`define ADDR_W 12
`define OFS_DEV_STATUS 12'h0c8
`define OFS_LINK_CAP 12'h0cc
`define OFS_IRQ_MASK 12'h0e0

// Status word fields
`define ST_ERR 19:16
`define ST_AUX 20
`define ST_PEND 21
`define ST_RSVD 31:22
`define ST_LOW 15:0
`define ERR_LSB 16
`define ERR_LANE 2
`define ERR_N 4
`define AUX_RST 1'h1
`define PEND_VAL 1'h0

// Capability word fields
`define CAP_SPEED 3:0
`define CAP_WIDTH 9:4
`define CAP_ASPM 11:10
`define CAP_L0S 14:12
`define CAP_L1 17:15
`define CAP_CPM 18
`define CAP_SDN 19
`define CAP_DLL 20
`define CAP_BWN 21
`define CAP_PORT 31:24
`define CAP_RSVD 23:22

// Capability reset codes
`define RST_SPEED 4'h2
`define RST_WIDTH 6'h01
`define RST_ASPM 2'h3
`define RST_L0S 3'h3
`define RST_L1 3'h5
`define RST_DLL 1'h0
`define RST_CPM_DN 1'h0
`define RST_CPM_UP 1'h1

// Fields that the load port may replace: ASPM, both latencies, CPM, port
`define OVR_MASK 32'hff07fc00

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- rtl/regs_pkg.sv ----
// Types shared by the port status and capability register block.
// Assumes regs_defines.svh is on the include path.
`include "regs_defines.svh"

package regs_pkg;

    // State of the error flag bank
    typedef struct packed {
        logic [`ERR_N-1:0] flags;
    } flag_state_t;

    // State of the register block and its bus slave
    typedef struct packed {
        logic [`ADDR_W-1:0] awaddr;
        logic aw_got;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] cap;
        logic [`ERR_N-1:0] mask;
        logic [1:0] aux_sync;
    } regs_state_t;

endpackage

// ---- rtl/err_flag_bank.sv ----
// Sticky error flags, set by hardware and cleared by write-one-to-clear.
// Assumes set and clear pulses come from logic on the same clock.
`timescale 1ns/1ps
`include "regs_defines.svh"

module err_flag_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Events and clears
    input wire logic [`ERR_N-1:0] set,
    input wire logic [`ERR_N-1:0] clr,
    // Flags
    output logic [`ERR_N-1:0] flags
);
    import regs_pkg::*;

    flag_state_t st_ff;
    flag_state_t nxt_st;
    logic [`ERR_N-1:0] nxt_bits;

    // Per flag: a set in the clearing cycle wins so no event is lost
    genvar i;
    generate
        for (i = 0; i < `ERR_N; i++) begin : g_flag
            assign nxt_bits[i] = set[i] | (st_ff.flags[i] & ~clr[i]);
        end
    endgenerate

    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.flags = nxt_bits;
    end

    // Flags reset clear
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign flags = st_ff.flags;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    set_wins_a: assert property (set[0] && clr[0] |=> flags[0])
        else $error("flag lost when set met clear");
    clr_works_a: assert property (clr[1] && !set[1] |=> !flags[1])
        else $error("flag not cleared by write of one");
    hold_flag_a: assert property (flags[2] && !clr[2] |=> flags[2])
        else $error("flag dropped without a clear");
endmodule

// ---- rtl/pcie_port_devstat_linkcap_regs.sv ----
// Device status and link capability registers of one switch port.
// Assumes error events are one-cycle pulses on clk and AXI4-Lite access.
// Contract
// - Correctable error sets status bit 16; reset zero; write one clears.
// - Non-fatal error sets status bit 17; reset zero; write one clears.
// - Fatal error sets status bit 18; reset zero; write one clears.
// - Unsupported request sets status bit 19; reset zero; write one clears.
// - Error flags set regardless of any reporting enable.
// - Status bit 20 shows auxiliary power present; resets to one.
// - Status bit 21, transactions pending, always reads zero.
// - Capability bits 3:0 give max speed; reset 0010b for 5.0 Gb/s.
// - Capability bits 9:4 give max width; reset to single lane.
// - Capability bits 17:15 give L1 exit latency, 16 to 32 us.
// - Capability bit 19 resets one downstream, zero upstream.
// - Capability bit 20 is zero on every port.
// - Capability bit 21 resets zero upstream, one downstream.
// - Capability bits 31:24 reset to the port index.
// - ASPM, latencies, clock PM and port number are loadable overrides.
`timescale 1ns/1ps
`include "regs_defines.svh"

module pcie_port_devstat_linkcap_regs #(
    parameter logic IS_UPSTREAM = 1'h1,
    parameter logic [7:0] PORT_INDEX = 8'h00
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Error detector events, one-cycle pulses
    input wire logic err_corr,
    input wire logic err_nonfatal,
    input wire logic err_fatal,
    input wire logic err_unsup,
    // Auxiliary power sense pin
    input wire logic aux_pwr_pin,
    // Serial-bus or EEPROM default load
    input wire logic ovr_load,
    input wire logic [31:0] ovr_data,
    // Interrupt
    output logic irq
);
    import regs_pkg::*;

    regs_state_t st_ff;
    regs_state_t nxt_st;
    logic [`ERR_N-1:0] err_flags;
    logic [`ERR_N-1:0] err_set;
    logic [`ERR_N-1:0] err_clr;
    logic [31:0] status_word;
    logic [31:0] cap_rst;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;
    logic wr_fire;
    logic rd_fire;
    logic wr_status;
    logic wr_mask;
    logic wr_known;

    // Word address match, ignoring the byte lane bits
    function automatic logic hit(input logic [`ADDR_W-1:0] a,
                                 input logic [`ADDR_W-1:0] ofs);
        hit = (a[`ADDR_W-1:2] == ofs[`ADDR_W-1:2]);
    endfunction

    // Reset image of the capability word, per port role
    always_comb begin
        cap_rst = 32'h0;
        cap_rst[`CAP_SPEED] = `RST_SPEED;
        cap_rst[`CAP_WIDTH] = `RST_WIDTH;
        cap_rst[`CAP_ASPM] = `RST_ASPM;
        cap_rst[`CAP_L0S] = `RST_L0S;
        cap_rst[`CAP_L1] = `RST_L1;
        cap_rst[`CAP_CPM] = IS_UPSTREAM ? `RST_CPM_UP : `RST_CPM_DN;
        cap_rst[`CAP_SDN] = ~IS_UPSTREAM;
        cap_rst[`CAP_DLL] = `RST_DLL;
        cap_rst[`CAP_BWN] = ~IS_UPSTREAM;
        cap_rst[`CAP_PORT] = PORT_INDEX;
    end

    // Events go straight to the flags; no enable gates them
    assign err_set = {err_unsup, err_fatal, err_nonfatal, err_corr};

    // Status word; only the synchronised aux level is read
    always_comb begin
        status_word = 32'h0;
        status_word[`ST_ERR] = err_flags;
        status_word[`ST_AUX] = st_ff.aux_sync[1];
        status_word[`ST_PEND] = `PEND_VAL;
    end

    // A write completes once address and data are both held
    assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign wr_status = wr_fire && hit(st_ff.awaddr, `OFS_DEV_STATUS);
    assign wr_mask = wr_fire && hit(st_ff.awaddr, `OFS_IRQ_MASK);
    assign wr_known = wr_status || wr_mask || hit(st_ff.awaddr, `OFS_LINK_CAP);

    // Write-one-to-clear, only through the lane that holds the flags
    always_comb begin
        err_clr = '0;
        if (wr_status && st_ff.wstrb[`ERR_LANE]) begin
            err_clr = st_ff.wdata[`ST_ERR];
        end
    end

    err_flag_bank u_flags (
        .clk(clk),
        .rst(rst),
        .set(err_set),
        .clr(err_clr),
        .flags(err_flags)
    );

    // Read mux; unmapped words answer SLVERR with zero data
    always_comb begin
        rd_word = 32'h0;
        rd_resp = `RESP_OKAY;
        if (hit(s_axi_araddr, `OFS_DEV_STATUS)) begin
            rd_word = status_word;
        end else if (hit(s_axi_araddr, `OFS_LINK_CAP)) begin
            rd_word = st_ff.cap;
        end else if (hit(s_axi_araddr, `OFS_IRQ_MASK)) begin
            rd_word[`ST_ERR] = st_ff.mask;
        end else begin
            rd_resp = `RESP_SLVERR;
        end
    end

    // Next state of the bus slave and registers
    always_comb begin
        nxt_st = st_ff;
        // Pin sampled twice before anyone looks at it
        nxt_st.aux_sync = {st_ff.aux_sync[0], aux_pwr_pin};
        // Write address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_st.awaddr = s_axi_awaddr;
            nxt_st.aw_got = 1'h1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
            nxt_st.w_got = 1'h1;
        end
        if (wr_fire) begin
            nxt_st.aw_got = 1'h0;
            nxt_st.w_got = 1'h0;
            nxt_st.bvalid = 1'h1;
            nxt_st.bresp = wr_known ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'h0;
        end
        // Mask register, same layout as the error flags
        if (wr_mask && st_ff.wstrb[`ERR_LANE]) begin
            nxt_st.mask = st_ff.wdata[`ST_ERR];
        end
        // Capability word ignores bus writes; only the load port changes it
        if (ovr_load) begin
            nxt_st.cap = (st_ff.cap & ~`OVR_MASK) | (ovr_data & `OVR_MASK);
        end
        // Read answer registered one edge after the address is taken
        if (rd_fire) begin
            nxt_st.rvalid = 1'h1;
            nxt_st.rdata = rd_word;
            nxt_st.rresp = rd_resp;
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'h0;
        end
    end

    // State register; aux sense reads present until the pin is seen
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.cap <= cap_rst;
            st_ff.aux_sync <= {`AUX_RST, `AUX_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Bus handshakes; one write and one read outstanding at most
    assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
    assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;

    // Level interrupt while any unmasked flag stands
    assign irq = |(err_flags & st_ff.mask);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence rd_status_s;
        rd_fire && hit(s_axi_araddr, `OFS_DEV_STATUS);
    endsequence

    sequence rd_cap_s;
        rd_fire && hit(s_axi_araddr, `OFS_LINK_CAP);
    endsequence

    sequence wr_clear_s(int b);
        wr_status && st_ff.wstrb[`ERR_LANE] && st_ff.wdata[`ERR_LSB + b];
    endsequence

    corr_flag_a: assert property (err_corr |=> err_flags[0])
        else $error("correctable error not logged");
    nonfatal_flag_a: assert property (err_nonfatal |=> err_flags[1])
        else $error("non-fatal error not logged");
    fatal_flag_a: assert property (err_fatal |=> err_flags[2])
        else $error("fatal error not logged");
    unsup_flag_a: assert property (err_unsup |=> err_flags[3])
        else $error("unsupported request not logged");
    corr_clear_a: assert property (wr_clear_s(0) and !err_corr |=> !err_flags[0])
        else $error("write of one did not clear flag");
    pend_zero_a: assert property (rd_status_s |=> s_axi_rvalid && !s_axi_rdata[`ST_PEND])
        else $error("pending bit read as one");
    aux_follow_a: assert property (aux_pwr_pin [*3] ##0 rd_status_s |=> s_axi_rdata[`ST_AUX])
        else $error("aux power level not reported");
    speed_read_a: assert property (rd_cap_s ##0 !ovr_load ##1 1 |-> s_axi_rdata == $past(st_ff.cap))
        else $error("capability read differs from stored word");
    cap_ro_a: assert property (wr_fire && !ovr_load |=> $stable(st_ff.cap))
        else $error("bus write changed capability word");
    port_reset_a: assert property ($fell(rst) |-> st_ff.cap[`CAP_PORT] == PORT_INDEX
                                   && st_ff.cap[`CAP_DLL] == 1'h0)
        else $error("port number or link-active bit wrong after reset");
    ovr_keep_a: assert property (ovr_load |=> st_ff.cap[`CAP_SPEED] == $past(st_ff.cap[`CAP_SPEED]))
        else $error("load port touched speed field");
    irq_level_a: assert property (err_corr && st_ff.mask[0] |=> irq || !st_ff.mask[0])
        else $error("unmasked flag raised no interrupt");
    wr_answer_a: assert property (wr_fire |=> s_axi_bvalid)
        else $error("write answer missing");
    wr_single_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    rd_single_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    rd_answer_a: assert property (rd_fire |=> s_axi_rvalid)
        else $error("read answer missing");
    unmapped_rd_a: assert property (rd_fire && !hit(s_axi_araddr, `OFS_DEV_STATUS)
                                    && !hit(s_axi_araddr, `OFS_LINK_CAP)
                                    && !hit(s_axi_araddr, `OFS_IRQ_MASK)
                                    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");

    // Clears of the other three flags; an event in the same cycle keeps the flag
    nonfatal_clear_a: assert property (wr_clear_s(1) and !err_nonfatal |=> !err_flags[1])
        else $error("write of one did not clear non-fatal flag");
    fatal_clear_a: assert property (wr_clear_s(2) and !err_fatal |=> !err_flags[2])
        else $error("write of one did not clear fatal flag");
    unsup_clear_a: assert property (wr_clear_s(3) and !err_unsup |=> !err_flags[3])
        else $error("write of one did not clear unsupported flag");

    // Flags stay until cleared and never appear without an event
    corr_hold_a: assert property (err_flags[0] && !err_clr[0] |=> err_flags[0])
        else $error("correctable flag dropped without a clear");
    nonfatal_hold_a: assert property (err_flags[1] && !err_clr[1] |=> err_flags[1])
        else $error("non-fatal flag dropped without a clear");
    fatal_hold_a: assert property (err_flags[2] && !err_clr[2] |=> err_flags[2])
        else $error("fatal flag dropped without a clear");
    unsup_hold_a: assert property (err_flags[3] && !err_clr[3] |=> err_flags[3])
        else $error("unsupported flag dropped without a clear");
    flags_quiet_a: assert property ((err_flags | err_set) == 4'h0 |=> err_flags == 4'h0)
        else $error("flag set with no event");

    // Capability reset image, checked at the first edge after reset
    sequence reset_done_s;
        $fell(rst);
    endsequence

    speed_reset_a: assert property (reset_done_s |-> st_ff.cap[`CAP_SPEED] == `RST_SPEED)
        else $error("speed field wrong after reset");
    width_reset_a: assert property (reset_done_s |-> st_ff.cap[`CAP_WIDTH] == `RST_WIDTH)
        else $error("width field wrong after reset");
    aspm_reset_a: assert property (reset_done_s |-> st_ff.cap[`CAP_ASPM] == `RST_ASPM)
        else $error("power state support wrong after reset");
    l0s_reset_a: assert property (reset_done_s |-> st_ff.cap[`CAP_L0S] == `RST_L0S)
        else $error("short exit latency wrong after reset");
    l1_reset_a: assert property (reset_done_s |-> st_ff.cap[`CAP_L1] == `RST_L1)
        else $error("long exit latency wrong after reset");
    cpm_reset_a: assert property (reset_done_s |->
                                  st_ff.cap[`CAP_CPM] == (IS_UPSTREAM ? `RST_CPM_UP : `RST_CPM_DN))
        else $error("clock power bit wrong after reset");
    sdn_reset_a: assert property (reset_done_s |-> st_ff.cap[`CAP_SDN] == !IS_UPSTREAM)
        else $error("surprise-down bit wrong after reset");
    bwn_reset_a: assert property (reset_done_s |-> st_ff.cap[`CAP_BWN] == !IS_UPSTREAM)
        else $error("bandwidth notify bit wrong after reset");

    // Fixed, reserved and read-only parts of both words
    dll_zero_a: assert property (rd_cap_s |=> !s_axi_rdata[`CAP_DLL])
        else $error("link-active bit read as one");
    status_rsvd_a: assert property (rd_status_s |=>
                                    s_axi_rdata[`ST_RSVD] == '0 && s_axi_rdata[`ST_LOW] == '0)
        else $error("reserved status bits not zero");
    cap_rsvd_a: assert property (rd_cap_s |=> s_axi_rdata[`CAP_RSVD] == '0)
        else $error("reserved capability bits not zero");
    cap_wr_okay_a: assert property (wr_fire && hit(st_ff.awaddr, `OFS_LINK_CAP) |=>
                                    s_axi_bresp == `RESP_OKAY)
        else $error("capability write not answered okay");

    // Load port replaces the loadable fields and nothing else
    ovr_fixed_a: assert property (ovr_load |=>
                                  (st_ff.cap & ~`OVR_MASK) == ($past(st_ff.cap) & ~`OVR_MASK))
        else $error("load port touched a fixed field");
    ovr_take_a: assert property (ovr_load |=>
                                 (st_ff.cap & `OVR_MASK) == ($past(ovr_data) & `OVR_MASK))
        else $error("load port value not taken");

    // Aux power going away shows once the synchroniser has passed it
    sequence aux_low_read_s;
        !aux_pwr_pin [*3] ##0 rd_status_s;
    endsequence

    aux_low_a: assert property (aux_low_read_s |=> !s_axi_rdata[`ST_AUX])
        else $error("aux power loss not reported");

    // Mask register and interrupt gating
    mask_write_a: assert property (wr_mask && st_ff.wstrb[`ERR_LANE] |=>
                                   st_ff.mask == $past(st_ff.wdata[`ST_ERR]))
        else $error("mask write not taken");
    mask_keep_a: assert property (!wr_mask |=> $stable(st_ff.mask))
        else $error("mask changed without a write");
    irq_masked_a: assert property (st_ff.mask == 4'h0 |-> !irq)
        else $error("interrupt raised while all masked");
endmodule

// ---- sim/pcie_port_devstat_linkcap_regs_test.sv ----
// Self-checking bench for the port status and capability register block.
// Assumes the design files and regs_defines.svh are compiled beforehand.
`timescale 1ns/1ps
`include "regs_defines.svh"

module pcie_port_devstat_linkcap_regs_test;
    // A downstream port with a non-zero index shows the port-dependent defaults
    localparam logic UP = 1'h0;
    localparam logic [7:0] PIDX = 8'h03;
    localparam logic [11:0] ST = 12'h0c8;
    localparam logic [11:0] CAP = 12'h0cc;
    localparam logic [11:0] MSK = 12'h0e0;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, ovr_data = 32'h0;
    logic [3:0] err_v = 4'h0;
    logic [3:0] wstrb = 4'hf;
    logic aux_pin = 1'h1, ovr_load = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int fails = 0;
    int samples_checked = 0;

    pcie_port_devstat_linkcap_regs #(.IS_UPSTREAM(UP), .PORT_INDEX(PIDX))
        pcie_port_devstat_linkcap_regs_i (
        .clk(clk), .rst(rst),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp),
        .err_corr(err_v[0]), .err_nonfatal(err_v[1]), .err_fatal(err_v[2]),
        .err_unsup(err_v[3]), .aux_pwr_pin(aux_pin),
        .ovr_load(ovr_load), .ovr_data(ovr_data), .irq(irq)
    );

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Bus write; address and data are released separately as each is taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic ad, wd;
        ad = 1'h0;
        wd = 1'h0;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(ad && wd) && n < 64) begin
            @(posedge clk);
            n++;
            if (awvalid && awready) begin
                ad = 1'h1;
                awvalid <= 1'h0;
            end
            if (wvalid && wready) begin
                wd = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do begin
            @(posedge clk);
            n++;
        end while (bvalid !== 1'h1 && n < 128);
        if (bvalid !== 1'h1) begin
            fails++;
            end_sim();
        end else begin
            r = bresp;
            bready <= 1'h0;
            @(posedge clk);
        end
    endtask

    // Bus read, checked against the expected word and response
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (!(arvalid && arready) && n < 64);
        arvalid <= 1'h0;
        do begin
            @(posedge clk);
            n++;
        end while (rvalid !== 1'h1 && n < 128);
        if (rvalid !== 1'h1) begin
            fails++;
            end_sim();
        end else begin
            check(rdata, e);
            check({30'h0, rresp}, {30'h0, er});
            rready <= 1'h0;
            @(posedge clk);
        end
    endtask

    // One-cycle error events; the spare edge keeps back-to-back calls apart
    task automatic pulse(input logic [3:0] e);
        err_v <= e;
        @(posedge clk);
        err_v <= 4'h0;
        @(posedge clk);
    endtask

    function automatic logic [31:0] st(input logic [3:0] f, input logic aux);
        return {10'h0, 1'h0, aux, f, 16'h0};
    endfunction

    // Capability image, optionally with the loadable fields replaced
    function automatic logic [31:0] cap_img(input logic [31:0] ov, input logic use_ov);
        logic [31:0] c;
        c = {PIDX, 2'h0, ~UP, 1'h0, ~UP, UP, 3'h5, 3'h3, 2'h3, 6'h01, 4'h2};
        if (use_ov) begin
            c = (c & ~32'hff07fc00) | (ov & 32'hff07fc00);
        end
        return c;
    endfunction

    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [3:0] fl, ev, mk, cl;
        d = $urandom(17143);
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        rd(ST, st(4'h0, 1'h1), `RESP_OKAY);
        rd(CAP, cap_img(32'h0, 1'h0), `RESP_OKAY);
        check({31'h0, irq}, 32'h0);
        // Each flag alone: a zero leaves it, a one clears it
        for (int i = 0; i < 4; i++) begin
            pulse(4'h1 << i);
            rd(ST, st(4'h1 << i, 1'h1), `RESP_OKAY);
            wr(ST, ~(32'h1 << (16 + i)), r);
            rd(ST, st(4'h1 << i, 1'h1), `RESP_OKAY);
            // A one outside the enabled byte lanes must not clear
            wstrb <= 4'hb;
            wr(ST, 32'h1 << (16 + i), r);
            wstrb <= 4'hf;
            rd(ST, st(4'h1 << i, 1'h1), `RESP_OKAY);
            wr(ST, 32'h1 << (16 + i), r);
            rd(ST, st(4'h0, 1'h1), `RESP_OKAY);
        end
        // Random events, clears, masks and writes to read-only places
        fl = 4'h0;
        for (int k = 0; k < 24; k++) begin
            ev = 4'($urandom);
            cl = 4'($urandom);
            mk = 4'($urandom);
            pulse(ev);
            fl = fl | ev;
            d = $urandom;
            d[19:16] = cl;
            wr(ST, d, r);
            check({30'h0, r}, {30'h0, `RESP_OKAY});
            fl = fl & ~cl;
            d = $urandom;
            d[19:16] = mk;
            wr(MSK, d, r);
            check({31'h0, irq}, {31'h0, |(fl & mk)});
            rd(ST, st(fl, 1'h1), `RESP_OKAY);
            rd(MSK, {12'h0, mk, 16'h0}, `RESP_OKAY);
            wr(CAP, $urandom, r);
            check({30'h0, r}, {30'h0, `RESP_OKAY});
            rd(CAP, cap_img(32'h0, 1'h0), `RESP_OKAY);
        end
        // Unmapped word answers an error and reads zero
        wr(12'h0f0, 32'hffffffff, r);
        check({30'h0, r}, {30'h0, `RESP_SLVERR});
        rd(12'h0f0, 32'h0, `RESP_SLVERR);
        // Default load replaces only the loadable fields
        d = $urandom;
        ovr_data <= d;
        ovr_load <= 1'h1;
        @(posedge clk);
        ovr_load <= 1'h0;
        @(posedge clk);
        rd(CAP, cap_img(d, 1'h1), `RESP_OKAY);
        // Auxiliary power goes away; allow the two-stage synchroniser
        aux_pin <= 1'h0;
        repeat (4) @(posedge clk);
        rd(ST, st(fl, 1'h0), `RESP_OKAY);
        aux_pin <= 1'h1;
        // Second reset with all flags set and unmasked
        pulse(4'hf);
        wr(MSK, 32'h000f0000, r);
        check({31'h0, irq}, 32'h1);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rd(ST, st(4'h0, 1'h1), `RESP_OKAY);
        rd(CAP, cap_img(32'h0, 1'h0), `RESP_OKAY);
        rd(MSK, 32'h0, `RESP_OKAY);
        end_sim();
    end
endmodule
